// File: design/zct_core.sv
// zero-cross trigger core: sawtooth, firing decision and centred gate pulses
`timescale 1ns/1ps

module zct_core
    import zct_pkg::*;
#(
    parameter int unsigned ENABLE_CYCLES = ENABLE_CYC,
    parameter int unsigned PULSE_CYCLES  = PULSE_W_CYC
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire zct_in_t           sense_in,
    output logic                   gate_req,
    output logic [SAW_W-1:0]       saw_level,
    output logic                   fire_active
);

    localparam logic [TMR_W-1:0]  HALF_W  = TMR_W'(PULSE_CYCLES / 2);
    localparam logic [TMR_W-1:0]  FULL_W  = TMR_W'(PULSE_CYCLES);
    localparam logic [TICK_W-1:0] TICK_LD = TICK_W'(ENABLE_CYCLES - 1);

    zct_in_t           in_s1_reg;
    zct_in_t           in_s2_reg;
    logic              mains_d_reg;
    logic              rise;
    logic              fall;
    logic [TMR_W-1:0]  tmr_reg;
    logic [TMR_W-1:0]  period_reg;
    logic [TMR_W-1:0]  high_reg;
    logic [1:0]        rises_reg;
    logic              valid;
    logic [SAW_W-1:0]  saw_reg;
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick;
    logic              demand_reg;
    logic              armed_reg;
    logic              arm_now;
    logic              fire_reg;
    logic              fire_next;
    logic              win_a;
    logic              win_b;
    logic              gate_reg;
    logic              gate_next;

    // two-stage synchroniser plus a delayed mains copy; only stage two feeds logic
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_s1_reg   <= IN_RST;
            in_s2_reg   <= IN_RST;
            mains_d_reg <= 1'b0;
        end else begin
            in_s1_reg   <= sense_in;
            in_s2_reg   <= in_s1_reg;
            mains_d_reg <= in_s2_reg.mains_pos;
        end
    end

    // crossing detection on the synchronised mains level
    assign rise = in_s2_reg.mains_pos & ~mains_d_reg;
    assign fall = ~in_s2_reg.mains_pos & mains_d_reg;

    // time since the last rising crossing, saturating if mains is lost
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tmr_reg <= TMR_RST;
        end else if (rise) begin
            tmr_reg <= TMR_RST;
        end else if (tmr_reg != TMR_MAX) begin
            tmr_reg <= tmr_reg + 20'h00001;
        end
    end

    // last full period and positive half length, used to predict crossings
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            period_reg <= TMR_RST;
            high_reg   <= TMR_RST;
            rises_reg  <= 2'h0;
        end else begin
            if (rise) begin
                period_reg <= tmr_reg + 20'h00001;
                if (rises_reg != VALID_RISES) begin
                    rises_reg <= rises_reg + 2'h1;
                end
            end
            if (fall) begin
                high_reg <= tmr_reg;
            end
        end
    end

    // no prediction possible until a full period has been measured
    assign valid = (rises_reg == VALID_RISES) && (period_reg > FULL_W) && (high_reg > HALF_W);

    // 11-bit counter
    // wraps naturally after 2048 rises, so the ramp never needs a compare
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            saw_reg <= SAW_RST;
        end else if (rise) begin
            saw_reg <= saw_reg + 11'h001;
        end
    end

    // reference offset out
    // registered copy feeds the reference summing DAC
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            saw_level <= SAW_RST;
        end else begin
            saw_level <= saw_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tick_cnt_reg <= TICK_LD;
        end else if (tick_cnt_reg == TICK_RST) begin
            tick_cnt_reg <= TICK_LD;
        end else begin
            tick_cnt_reg <= tick_cnt_reg - 23'h000001;
        end
    end

    assign tick = (tick_cnt_reg == TICK_RST);

    // sampled at enable
    // sampling slowly trades response time for immunity to comparator chatter
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            demand_reg <= 1'b0;
        end else if (tick) begin
            demand_reg <= in_s2_reg.demand & ~in_s2_reg.failsafe;
        end
    end

    // arm at pair start
    // pair starts where the rising-crossing pulse is predicted to begin;
    // an early rise arms the pair itself so no pair is skipped
    assign arm_now = valid & ((~armed_reg & (tmr_reg == period_reg - HALF_W)) | (rise & ~armed_reg));

    always_comb begin
        fire_next = fire_reg;
        if (!valid) begin
            fire_next = 1'b0;
        end else if (arm_now) begin
            fire_next = demand_reg;
        end
    end

    // armed from pair start until the falling-crossing pulse is over
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            armed_reg <= 1'b0;
        end else if (!valid) begin
            armed_reg <= 1'b0;
        end else if (arm_now) begin
            armed_reg <= 1'b1;
        end else if (!rise && tmr_reg == high_reg + HALF_W) begin
            armed_reg <= 1'b0;
        end
    end

    // centred windows
    // window a straddles the rising crossing, window b the falling one
    assign win_a = armed_reg ? ((tmr_reg >= period_reg - HALF_W) | (tmr_reg < HALF_W)) : arm_now;
    assign win_b = (tmr_reg >= high_reg - HALF_W) && (tmr_reg < high_reg + HALF_W);

    // even count per burst
    // failsafe acts at once: safety outranks pairing, the last pair may be cut
    always_comb begin
        gate_next = 1'b0;
        if (valid && fire_next && !in_s2_reg.failsafe) begin
            gate_next = win_a | (armed_reg & win_b);
        end
    end

    // decision and gate registered together; fire_active mirrors the internal copy
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fire_reg    <= 1'b0;
            fire_active <= 1'b0;
            gate_reg    <= 1'b0;
        end else begin
            fire_reg    <= fire_next;
            fire_active <= fire_next;
            gate_reg    <= gate_next;
        end
    end

    assign gate_req = gate_reg;

    // helper: length of the current gate pulse
    logic [TMR_W-1:0] plen_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            plen_reg <= TMR_RST;
        end else if (gate_reg) begin
            plen_reg <= plen_reg + 20'h00001;
        end else begin
            plen_reg <= TMR_RST;
        end
    end

    property p_saw_step;
        @(posedge clk_sys) disable iff (rst)
        rise |=> (saw_reg == $past(saw_reg) + 11'h001);
    endproperty
    a_saw_step: assert property (p_saw_step) else $error("ramp did not step on rise");
    property p_saw_wrap;
        @(posedge clk_sys) disable iff (rst)
        (rise && saw_reg == SAW_LAST) |=> (saw_reg == SAW_RST);
    endproperty
    a_saw_wrap: assert property (p_saw_wrap) else $error("ramp did not restart");
    property p_saw_hold;
        @(posedge clk_sys) disable iff (rst)
        !rise |=> $stable(saw_reg);
    endproperty
    a_saw_hold: assert property (p_saw_hold) else $error("ramp moved without a period");
    property p_saw_out;
        @(posedge clk_sys) disable iff (rst)
        rise ##1 1'b1 |=> (saw_level == $past(saw_reg));
    endproperty
    a_saw_out: assert property (p_saw_out) else $error("reference offset lags");
    property p_demand_tick;
        @(posedge clk_sys) disable iff (rst)
        !tick |=> $stable(demand_reg);
    endproperty
    a_demand_tick: assert property (p_demand_tick) else $error("demand moved off enable");

    property p_no_demand;
        @(posedge clk_sys) disable iff (rst)
        !fire_reg |-> !gate_reg;
    endproperty
    a_no_demand: assert property (p_no_demand) else $error("gate without firing decision");

    property p_failsafe;
        @(posedge clk_sys) disable iff (rst)
        in_s2_reg.failsafe |=> !gate_reg;
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("gate during failsafe");

    property p_fire_arm;
        @(posedge clk_sys) disable iff (rst)
        (valid && $past(valid) && !$past(arm_now)) |-> (fire_reg == $past(fire_reg));
    endproperty
    a_fire_arm: assert property (p_fire_arm) else $error("decision changed mid pair");

    property p_rise_pulse;
        @(posedge clk_sys) disable iff (rst)
        (rise && armed_reg && fire_next && valid && !in_s2_reg.failsafe) |=> gate_reg;
    endproperty
    a_rise_pulse: assert property (p_rise_pulse) else $error("no pulse at rising crossing");

    property p_fall_pulse;
        @(posedge clk_sys) disable iff (rst)
        (fall && armed_reg && fire_next && valid && !in_s2_reg.failsafe
         && high_reg > HALF_W) |=> gate_reg;
    endproperty
    a_fall_pulse: assert property (p_fall_pulse) else $error("no pulse at falling crossing");

    property p_width;
        @(posedge clk_sys) disable iff (rst)
        plen_reg <= FULL_W + 20'h00001;
    endproperty
    a_width: assert property (p_width) else $error("gate pulse too long");

    property p_tick_load;
        @(posedge clk_sys) disable iff (rst)
        tick |=> (tick_cnt_reg == TICK_LD);
    endproperty
    a_tick_load: assert property (p_tick_load) else $error("enable divider not reloaded");

endmodule

// File: design/zct_pkg.sv
// shared constants and carrier types for the zero-cross trigger core
package zct_pkg;

    // system clock rate
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned NS_PER_S      = 1_000_000_000;
    localparam int unsigned US_PER_S      = 1_000_000;

    // sawtooth: one full ramp spans this many mains periods
    localparam int unsigned SAW_PERIODS   = 2048;
    localparam int unsigned SAW_W         = 11;
    localparam logic [10:0] SAW_RST       = 11'h000;
    localparam logic [10:0] SAW_LAST      = 11'h7ff;

    // firing enable instants, a third of a second apart
    localparam int unsigned ENABLE_DIV    = 3;
    localparam int unsigned ENABLE_CYC    = CLK_HZ / ENABLE_DIV;
    localparam int unsigned TICK_W        = 23;
    localparam logic [22:0] TICK_RST      = 23'h000000;

    // gate pulse width, centred on the crossing
    localparam int unsigned PULSE_W_US    = 75;
    localparam int unsigned PULSE_W_CYC   = PULSE_W_US * (CLK_HZ / US_PER_S);

    // mains timer: 20 bits cover periods down to about 19 Hz
    localparam int unsigned TMR_W         = 20;
    localparam logic [19:0] TMR_RST       = 20'h00000;
    localparam logic [19:0] TMR_MAX       = 20'hfffff;

    // number of rising crossings before period figures are trusted
    localparam logic [1:0]  VALID_RISES   = 2'h2;

    // inputs that arrive from the analog side, carried together
    typedef struct packed {
        logic mains_pos;  // high during the positive mains half-cycle
        logic demand;     // comparator: sense below reference plus sawtooth
        logic failsafe;   // sense above the failsafe threshold
    } zct_in_t;

    localparam zct_in_t IN_RST = '{mains_pos: 1'b0, demand: 1'b0, failsafe: 1'b1};

endpackage

// File: testbench/tb_top.sv
// self-checking bench for the zero-cross trigger core
`timescale 1ns/1ps
module tb_top;
    import zct_pkg::*;
    localparam int unsigned PW_C = 8;
    logic             clk_sys     = 1'b0;
    logic             rst         = 1'b1;
    logic [SAW_W-1:0] sense_lvl   = 11'h7ff;
    logic             open_sensor = 1'b0;
    zct_in_t          sense_in;
    logic             gate_req;
    logic [SAW_W-1:0] saw_level;
    logic             fire_active;
    int               err_count   = 0;
    int               comparisons = 0;
    int               seed        = 32'h254c6aa0;
    logic [SAW_W-1:0] exp_q[$];
    logic [SAW_W-1:0] exp_saw     = 11'h000;
    logic [SAW_W-1:0] saw_d       = 11'h000;
    logic             gate_d      = 1'b0;
    logic             mains_d     = 1'b0;
    logic             fire_d      = 1'b0;
    logic             fs_seen     = 1'b0;
    int               cyc         = 0;
    int               g_start     = 0;
    int               edge_t      = 0;
    int               fs_run      = 0;
    int               burst       = 0;

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    zct_core #(.ENABLE_CYCLES(200), .PULSE_CYCLES(PW_C)) i_dut (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .sense_in    (sense_in),
        .gate_req    (gate_req),
        .saw_level   (saw_level),
        .fire_active (fire_active)
    );

    zct_mains_model #(.HALF_CYC(16)) i_mains (
        .clk_sys     (clk_sys),
        .rst         (rst),
        .sense_lvl   (sense_lvl),
        .saw_level   (saw_level),
        .open_sensor (open_sensor),
        .sense_out   (sense_in)
    );

    task automatic compare_saw(input logic [SAW_W-1:0] e, input logic [SAW_W-1:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("BAD saw_level expected %h seen %h", e, g);
        end
    endtask

    task automatic compare_bit(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // bounded wait on the firing decision; a timeout ends the run
    task automatic wait_fire(input logic lvl, input int lim);
        int n;
        n = 0;
        while (fire_active !== lvl && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        compare_bit("fire_active", lvl, fire_active);
        if (fire_active !== lvl) begin
            summarize();
        end
    endtask

    // each rising crossing notes the next ramp value, wrapping after a full ramp
    always @(posedge clk_sys) begin
        mains_d <= sense_in.mains_pos;
        if (!rst && sense_in.mains_pos && !mains_d) begin
            exp_saw = (exp_saw == 11'(SAW_PERIODS - 1)) ? 11'h000 : exp_saw + 11'h001;
            exp_q.push_back(exp_saw);
        end
    end

    // output watcher: ramp steps, pulse shape, failsafe and burst parity
    always @(posedge clk_sys) begin
        cyc    <= cyc + 1;
        saw_d  <= saw_level;
        gate_d <= gate_req;
        fire_d <= fire_active;
        fs_run <= open_sensor ? fs_run + 1 : 0;
        if (sense_in.mains_pos != mains_d) edge_t <= cyc;
        if (!rst) begin
            if (saw_level !== saw_d)
                compare_saw(exp_q.size() > 0 ? exp_q.pop_front() : 'x, saw_level);
            if (gate_req && !gate_d) begin
                g_start <= cyc;
                burst   <= burst + 1;
                if (sense_lvl != 11'h7ff)
                    compare_bit("demand_gate", 1'b1, saw_level > sense_lvl);
            end
            if (!gate_req && gate_d) begin
                compare_bit("pulse_width", 1'b1, (cyc - g_start) inside {[PW_C - 1:PW_C + 1]});
                compare_bit("pulse_centre", 1'b1, (g_start + cyc - 2 * edge_t) inside {[2:10]});
            end
            if (fs_run > 5) compare_bit("failsafe_gate", 1'b0, gate_req);
            if (open_sensor) fs_seen <= 1'b1;
            if (fire_active && !fire_d) begin
                burst   <= (gate_req && !gate_d) ? 1 : 0;
                fs_seen <= open_sensor;
            end
            // a burst cut by the failsafe may legally be odd
            if (!fire_active && fire_d && !fs_seen)
                compare_bit("even_burst", 1'b0, burst[0]);
        end
    end

    // main sequence: ramp up to demand, failsafe cut, demand off, ramp wrap
    initial begin
        int n;
        repeat (20) @(posedge clk_sys);
        rst       <= 1'b0;
        sense_lvl <= 11'h12c + 11'($random(seed) & 32'hff);
        wait_fire(1'b1, 30000);
        // onset lands between gate windows, so no pulse is cut short by the blanking
        repeat (1512) @(posedge clk_sys);
        open_sensor <= 1'b1;
        repeat (320) @(posedge clk_sys);
        open_sensor <= 1'b0;
        wait_fire(1'b1, 2000);
        repeat (1000 + ($random(seed) & 32'hff)) @(posedge clk_sys);
        sense_lvl <= 11'h7ff;
        wait_fire(1'b0, 2000);
        n = 0;
        while (saw_level !== 11'h000 && n < 70000) begin
            @(posedge clk_sys);
            n++;
        end
        compare_saw(11'h000, saw_level);
        repeat (200) @(posedge clk_sys);
        summarize();
    end
endmodule

// File: testbench/zct_mains_model.sv
// mains crossing source and sense comparator model for the trigger core
`timescale 1ns/1ps
module zct_mains_model
    import zct_pkg::*;
#(
    parameter int unsigned HALF_CYC = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [SAW_W-1:0] sense_lvl,
    input  wire logic [SAW_W-1:0] saw_level,
    input  wire logic             open_sensor,
    output zct_in_t               sense_out
);
    logic [7:0] ph_reg   = 8'h00;
    logic       mains_reg = 1'b0;
    logic       dem_reg   = 1'b0;
    logic       fs_reg    = 1'b1;

    // mains held low in reset so no rising crossing is lost in the sync
    always @(posedge clk_sys) begin
        ph_reg    <= (rst || ph_reg == 8'(2 * HALF_CYC - 1)) ? 8'h00 : ph_reg + 8'h01;
        mains_reg <= !rst && ph_reg >= 8'(HALF_CYC);
        dem_reg   <= sense_lvl < saw_level;
        fs_reg    <= open_sensor;
    end

    assign sense_out = '{mains_pos: mains_reg, demand: dem_reg, failsafe: fs_reg};
endmodule
